// ---- cscr_pkg.sv ----
// constants, field layout and carrier types of the converter register bank
// assumes an 8-bit register map reached over a 24-bit serial frame
`default_nettype none
package cscr_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int PHASES = 6;
  localparam int SNAP_N = 16;
  // register addresses
  localparam logic [6:0] A_OC = 7'h02;
  localparam logic [6:0] A_NOC = 7'h03;
  localparam logic [6:0] A_STAT = 7'h04;
  localparam logic [6:0] A_CFG1 = 7'h05;
  localparam logic [6:0] A_CFG2 = 7'h06;
  localparam logic [6:0] A_CTRL = 7'h07;
  localparam logic [6:0] A_TRIM = 7'h08;
  // chip control fields
  localparam int CTRL_CML_BIT = 2;
  localparam int CTRL_RST_BIT = 1;
  localparam int CTRL_WP_BIT = 0;
  // status fields
  localparam int STAT_SS_BIT = 2;
  localparam int STAT_MAX_BIT = 1;
  localparam int STAT_WIN_BIT = 0;
  // first configuration fields
  localparam int CFG1_OVR_BIT = 5;
  localparam int CFG1_DRV_LSB = 3;
  localparam int CFG1_THR_LSB = 0;
  // second configuration fields
  localparam int CFG2_BURST_BIT = 4;
  localparam int CFG2_DCM_BIT = 3;
  localparam int CFG2_HIZ_BIT = 2;
  localparam int CFG2_SPREAD_SWITCHING_ACTIVE_BIT = 1;
  localparam int CFG2_BUCK_BIT = 0;
  // trim dac
  localparam int TRIM_SIGN_BIT = 6;
  localparam logic [7:0] TRIM_MASK = 8'h7f;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam logic WP_RESET = 1'b0;
  localparam logic CML_RESET = 1'b0;
  // serial frame
  localparam logic [7:0] PEC_INIT = 8'h41;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] PEC_BITS = 5'h10;
  localparam logic [4:0] FRAME_BITS = 5'h18;
  localparam logic [4:0] CNT_SAT = 5'h19;

  typedef struct packed {
    logic [PHASES-1:0] overcurrent;
    logic [PHASES-1:0] reverse_current;
    logic ss_done;
    logic max_current;
    logic output_in_window;
    logic current_pin_overrange;
    logic [1:0] driver_supply_level;
    logic [2:0] sense_threshold_code;
    logic burst;
    logic discontinuous_conduction;
    logic outputs_high_impedance;
    logic spread_switching_active;
    logic buck_mode;
  } cscr_pins_t;

  localparam int PINS_W = $bits(cscr_pins_t);

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cscr_wreq_t;
endpackage : cscr_pkg
`default_nettype wire

// ---- cscr_sync.sv ----
// two-flop level synchroniser, one per bit of a vector
// assumes the destination clock and its active-low reset
`default_nettype none
module cscr_sync
  import cscr_pkg::*;
#(
  parameter int W = 1
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else if (ce)
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : cscr_sync
`default_nettype wire

// ---- cscr_pec.sv ----
// one serial step of the 8-bit packet error code, x^8+x^2+x+1
// assumes the caller holds the running code in a register
`default_nettype none
module cscr_pec
  import cscr_pkg::*;
(
  // running code and new bit
  input wire logic [7:0] pec_in,
  input wire logic bit_in,
  output logic [7:0] pec_out
);
  logic in0;

  always_comb
  begin
    in0 = bit_in ^ pec_in[7];
    pec_out = {pec_in[6:2], pec_in[1] ^ in0, pec_in[0] ^ in0, in0};
  end
endmodule : cscr_pec
`default_nettype wire

// ---- cscr_top.sv ----
// status and control register bank of a six-phase converter controller
// assumes a serial master on sclk/csb/sdi/sdo and asynchronous status pins
//
// Summary of operation
// R1: phase overcurrent flags in bits 5:0, phase 1 at bit 0, 7:6 zero
// R2: phase negative overcurrent flags in bits 5:0, phase 1 at bit 0
// R3: status bit 2 shows soft-start finished
// R4: status bit 1 shows maximum current reached
// R5: status bit 0 shows output inside window; bits 7:3 zero
// R6: config1 bit 5 shows current pin above its range; 7:6 zero
// R7: config1 bits 4:3 show driver supply level code
// R8: config1 bits 2:0 show sense threshold code
// R9: config2 bit 4 burst, bit 3 discontinuous; bits 7:5 zero
// R10: config2 bit 2 shows outputs in high impedance
// R11: config2 bit 1 shows spread switching active
// R12: config2 bit 0 shows direction, 1 step-down, 0 step-up
// R13: control bit 2 set when a write fails its check code
// R14: writing 1 clears the comm error flag; 0 leaves it
// R15: writing 1 to control bit 1 restores all read/write registers
// R16: control bit 0 high blocks writes to the trim dac
// R17: trim register is 7-bit two's complement; bit 7 reserved
// R18: trim sign bit 0 sources current, 1 sinks
// R19: trim current reaches the low-side node only in step-down mode
// R20: trim register resets to 0x00
// R21: writes load on the 24th falling sclk edge after check passes
// R22: reserved bits read zero; read-only and reserved writes ignored
`default_nettype none
module cscr_top
  import cscr_pkg::*;
(
  // system clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // serial link
  input wire logic sclk,
  input wire logic csb,
  input wire logic sdi,
  output logic sdo_out,
  output logic sdo_oe,
  // converter status pins
  input wire cscr_pins_t status_pins,
  // low-side trim dac drive
  output logic [6:0] trim_code,
  output logic trim_sink,
  output logic trim_active
);
  // reset release
  logic [1:0] rst_sr_r;
  logic rst_n;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rst_sr_r <= 2'h0;
    else
      rst_sr_r <= {rst_sr_r[0], 1'b1};
  end

  assign rst_n = rst_sr_r[1];

  // register read value by index
  function automatic logic [7:0] read_value(
    input logic [3:0] idx,
    input cscr_pins_t p,
    input logic comm_error_flag,
    input logic wp,
    input logic [7:0] trim
  );
    logic [7:0] v;
    v = 8'h00;
    if ({3'h0, idx} == A_OC)
      v[PHASES-1:0] = p.overcurrent; // R1
    else if ({3'h0, idx} == A_NOC)
      v[PHASES-1:0] = p.reverse_current; // R2
    else if ({3'h0, idx} == A_STAT)
    begin
      v[STAT_SS_BIT] = p.ss_done; // R3
      v[STAT_MAX_BIT] = p.max_current; // R4
      v[STAT_WIN_BIT] = p.output_in_window; // R5
    end
    else if ({3'h0, idx} == A_CFG1)
    begin
      v[CFG1_OVR_BIT] = p.current_pin_overrange; // R6
      v[CFG1_DRV_LSB +: 2] = p.driver_supply_level; // R7
      v[CFG1_THR_LSB +: 3] = p.sense_threshold_code; // R8
    end
    else if ({3'h0, idx} == A_CFG2)
    begin
      v[CFG2_BURST_BIT] = p.burst; // R9
      v[CFG2_DCM_BIT] = p.discontinuous_conduction; // R9
      v[CFG2_HIZ_BIT] = p.outputs_high_impedance; // R10
      v[CFG2_SPREAD_SWITCHING_ACTIVE_BIT] = p.spread_switching_active; // R11
      v[CFG2_BUCK_BIT] = p.buck_mode; // R12
    end
    else if ({3'h0, idx} == A_CTRL)
    begin
      v[CTRL_CML_BIT] = comm_error_flag;
      v[CTRL_RST_BIT] = 1'b0;
      v[CTRL_WP_BIT] = wp;
    end
    else if ({3'h0, idx} == A_TRIM)
      v = trim & TRIM_MASK; // R17
    return v; // R22
  endfunction : read_value

  // link-domain signals
  logic [4:0] bit_cnt_r;
  logic [23:0] in_sr_r;
  logic [7:0] pec_r;
  logic [7:0] pec_nxt;
  logic [7:0] out_sr_r;
  logic pec_bit;
  logic wr_tgl_r;
  logic err_tgl_r;
  cscr_wreq_t wreq_r;

  // system-domain signals
  cscr_pins_t pins_s;
  logic [2:0] link_s;
  logic wr_seen_r;
  logic err_seen_r;
  logic wr_pulse;
  logic err_pulse;
  logic [7:0] trim_r;
  logic wp_r;
  logic cml_r;
  logic soft_rst;
  logic ctrl_wr;
  logic trim_wr;
  logic cml_clr;
  logic [7:0] snap_r [SNAP_N];
  logic [7:0] rd_byte;

  // status pins into the system clock
  cscr_sync #(
    .W(PINS_W)
  ) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .d(status_pins),
    .q(pins_s)
  );

  // frame select and link event toggles into the system clock
  cscr_sync #(
    .W(3)
  ) u_link_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .d({csb, wr_tgl_r, err_tgl_r}),
    .q(link_s)
  );

  // link side: bit counter, input shift, running check code
  assign pec_bit = (sdo_oe && bit_cnt_r >= BYTE_BITS) ? sdo_out : sdi;

  cscr_pec u_pec (
    .pec_in(pec_r),
    .bit_in(pec_bit),
    .pec_out(pec_nxt)
  );

  always_ff @(posedge sclk or posedge csb)
  begin
    if (csb)
      bit_cnt_r <= 5'h00;
    else if (bit_cnt_r != CNT_SAT)
      bit_cnt_r <= bit_cnt_r + 5'h01;
  end

  always_ff @(posedge sclk or posedge csb)
  begin
    if (csb)
      in_sr_r <= 24'h000000;
    else if (bit_cnt_r < FRAME_BITS)
      in_sr_r <= {in_sr_r[22:0], sdi};
  end

  always_ff @(posedge sclk or posedge csb)
  begin
    if (csb)
      pec_r <= PEC_INIT;
    else if (bit_cnt_r < PEC_BITS)
      pec_r <= pec_nxt;
  end

  // snapshot byte for the addressed register
  always_comb
  begin
    rd_byte = 8'h00;
    if (in_sr_r[7:5] == 3'h0)
      rd_byte = snap_r[in_sr_r[4:1]];
  end

  // link side: read data and check code out on falling edges
  always_ff @(negedge sclk or posedge csb)
  begin
    if (csb)
    begin
      sdo_out <= 1'b0;
      sdo_oe <= 1'b0;
      out_sr_r <= 8'h00;
    end
    else if (bit_cnt_r == BYTE_BITS && in_sr_r[0])
    begin
      sdo_oe <= 1'b1;
      sdo_out <= rd_byte[7];
      out_sr_r <= {rd_byte[6:0], 1'b0};
    end
    else if (bit_cnt_r == PEC_BITS && sdo_oe)
    begin
      sdo_out <= pec_r[7];
      out_sr_r <= {pec_r[6:0], 1'b0};
    end
    else if (sdo_oe)
    begin
      sdo_out <= out_sr_r[7];
      out_sr_r <= {out_sr_r[6:0], 1'b0};
    end
  end

  // link side: checked write hand-off at the end of the frame
  always_ff @(negedge sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_tgl_r <= 1'b0;
      err_tgl_r <= 1'b0;
      wreq_r <= '0;
    end
    else if (!csb && bit_cnt_r == FRAME_BITS && !in_sr_r[16])
    begin
      if (in_sr_r[7:0] == pec_r)
      begin
        wreq_r.addr <= in_sr_r[23:17]; // R21
        wreq_r.data <= in_sr_r[15:8]; // R21
        wr_tgl_r <= ~wr_tgl_r; // R21
      end
      else
        err_tgl_r <= ~err_tgl_r; // R13
    end
  end

  // system side: event edges from the toggles
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_seen_r <= 1'b0;
      err_seen_r <= 1'b0;
    end
    else if (ce)
    begin
      wr_seen_r <= link_s[1];
      err_seen_r <= link_s[0];
    end
  end

  assign wr_pulse = link_s[1] ^ wr_seen_r;
  assign err_pulse = link_s[0] ^ err_seen_r;
  assign ctrl_wr = wr_pulse && wreq_r.addr == A_CTRL;
  assign soft_rst = ctrl_wr && wreq_r.data[CTRL_RST_BIT];

  // write decodes
  assign trim_wr = wr_pulse && wreq_r.addr == A_TRIM && !wp_r; // R16
  assign cml_clr = ctrl_wr && wreq_r.data[CTRL_CML_BIT]; // R14

  // write protection
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wp_r <= WP_RESET;
    else if (ce)
    begin
      if (soft_rst)
        wp_r <= WP_RESET; // R15
      else if (ctrl_wr)
        wp_r <= wreq_r.data[CTRL_WP_BIT];
    end
  end

  // communication error flag, set wins over clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cml_r <= CML_RESET;
    else if (ce)
    begin
      if (err_pulse)
        cml_r <= 1'b1; // R13
      else if (cml_clr)
        cml_r <= 1'b0; // R14
    end
  end

  // low-side trim dac register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      trim_r <= TRIM_RESET; // R20
    else if (ce)
    begin
      if (soft_rst)
        trim_r <= TRIM_RESET; // R15
      else if (trim_wr) // R16
        trim_r <= wreq_r.data & TRIM_MASK; // R22
    end
  end

  // trim drive, injected only in step-down mode
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trim_code <= 7'h00;
      trim_sink <= 1'b0;
      trim_active <= 1'b0;
    end
    else if (ce)
    begin
      trim_code <= pins_s.buck_mode ? trim_r[6:0] : 7'h00; // R19
      trim_sink <= pins_s.buck_mode && trim_r[TRIM_SIGN_BIT]; // R18
      trim_active <= pins_s.buck_mode && trim_r[6:0] != 7'h00; // R19
    end
  end

  // read snapshot, refreshed only while no frame is open
  genvar gi;
  generate
    for (gi = 0; gi < SNAP_N; gi++)
    begin : g_snap
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          snap_r[gi] <= 8'h00;
        else if (ce && link_s[2])
          snap_r[gi] <= read_value(4'(gi), pins_s, cml_r, wp_r, trim_r);
      end
    end
  endgenerate
endmodule : cscr_top
`default_nettype wire

// ---- cscr_top_monitor.sv ----
// assertions on the ports of the register bank
// assumes binding into cscr_top
`default_nettype none
module cscr_top_monitor
  import cscr_pkg::*;
(
  // clocks and resets
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic sclk,
  input wire logic csb,
  // observed
  input wire logic sdi,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  input wire cscr_pins_t status_pins,
  input wire logic [6:0] trim_code,
  input wire logic trim_sink,
  input wire logic trim_active
);
  logic [4:0] bits_r;
  logic rw_r;
  // bit count and direction of the current frame
  always_ff @(posedge sclk or posedge csb)
  begin
    if (csb)
      bits_r <= 5'h00;
    else if (bits_r != CNT_SAT)
      bits_r <= bits_r + 5'h01;
  end
  always_ff @(posedge sclk or posedge csb)
  begin
    if (csb)
      rw_r <= 1'b0;
    else if (bits_r == 5'h07)
      rw_r <= sdi;
  end
  sequence s_boost_held;
    (ce && !status_pins.buck_mode)[*8];
  endsequence
  a_sink_sign: assert property (@(posedge clk) disable iff (!nrst)
    trim_sink == trim_code[6]) else $error("sink flag wrong");
  a_active_nonzero: assert property (@(posedge clk) disable iff (!nrst)
    trim_active == (trim_code != 7'h00)) else $error("active flag wrong");
  a_boost_zero: assert property (@(posedge clk) disable iff (!nrst)
    s_boost_held |-> trim_code == 7'h00) else $error("trim in step-up");
  a_boost_quiet: assert property (@(posedge clk) disable iff (!nrst)
    s_boost_held |-> !trim_sink && !trim_active) else $error("trim flags");
  a_ce_freeze: assert property (@(posedge clk) disable iff (!nrst)
    !ce |=> $stable(trim_code)) else $error("trim moved while frozen");
  a_reset_trim: assert property (@(posedge clk) disable iff (!nrst)
    $rose(nrst) |-> trim_code == 7'h00) else $error("trim not cleared");
  a_oe_idle: assert property (@(posedge clk) disable iff (!nrst)
    csb |-> !sdo_oe) else $error("output driven while deselected");
  a_oe_read: assert property (@(negedge sclk) disable iff (csb)
    sdo_oe |-> rw_r && bits_r >= 5'h08) else $error("output too early");
endmodule : cscr_top_monitor
bind cscr_top cscr_top_monitor u_mon (.clk(clk), .nrst(nrst), .ce(ce),
  .sclk(sclk), .csb(csb), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
  .status_pins(status_pins), .trim_code(trim_code), .trim_sink(trim_sink),
  .trim_active(trim_active));
`default_nettype wire

// ---- cscr_host.sv ----
// serial host model driving 24-bit frames with check code
// assumes the device samples on rising and drives on falling sclk
`default_nettype none
module cscr_host
(
  // serial link
  output logic sclk,
  output logic csb,
  output logic sdi,
  input wire logic sdo_out,
  input wire logic sdo_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic alt_r = 1'b0;
  wire logic line;
  // released line shows a changing pattern
  assign line = sdo_oe ? sdo_out : alt_r;
  always @(posedge sclk) alt_r <= ~alt_r;
  initial
  begin
    sclk = 1'b0;
    csb = 1'b1;
    sdi = 1'b0;
  end
  function automatic logic [7:0] pec8(input logic [15:0] v);
    logic [7:0] p;
    logic i0;
    p = 8'h41;
    for (int i = 15; i >= 0; i--)
    begin
      i0 = v[i] ^ p[7];
      p = {p[6:2], p[1] ^ i0, p[0] ^ i0, i0};
    end
    return p;
  endfunction : pec8
  // one frame; bad flips bit 0 of the check code
  task automatic xfer(input logic [7:0] b1, input logic [7:0] b2,
    input logic bad, output logic [15:0] rx);
    logic [23:0] f;
    f = {b1, b2, pec8({b1, b2}) ^ {7'h00, bad}};
    rx = 16'h0000;
    csb = 1'b0;
    #400;
    for (int i = 23; i >= 0; i--)
    begin
      sdi = f[i];
      #15 sclk = 1'b1;
      rx = {rx[14:0], line};
      #15 sclk = 1'b0;
    end
    #15; // select held past the last falling edge
    csb = 1'b1;
    sdi = 1'b0;
    #465;
  endtask : xfer
endmodule : cscr_host
`default_nettype wire

// ---- converter_status_control_regs_tb.sv ----
// self-checking bench for the converter register bank
// assumes cscr_top and the serial host model cscr_host
`default_nettype none
module converter_status_control_regs_tb;
  import cscr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  cscr_pins_t pins = '0;
  wire logic sclk, csb, sdi, sdo_out, sdo_oe, trim_sink, trim_active;
  wire logic [6:0] trim_code;
  int err_count = 0;
  int checks_done = 0;
  cscr_top DUT (.clk(clk), .nrst(nrst), .ce(ce), .sclk(sclk), .csb(csb),
    .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .status_pins(pins),
    .trim_code(trim_code), .trim_sink(trim_sink), .trim_active(trim_active));
  cscr_host u_host (.sclk(sclk), .csb(csb), .sdi(sdi), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe));
  initial
  begin
    forever #50 clk = ~clk;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [7:0] d,
    input logic bad = 1'b0);
    logic [15:0] rx;
    u_host.xfer({a, 1'b0}, d, bad, rx);
    repeat (3) @(negedge clk);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    logic [15:0] rx;
    u_host.xfer({a, 1'b1}, 8'h00, 1'b0, rx);
    chk(rx[15:8], exp);
    chk(rx[7:0], u_host.pec8({a, 1'b1, exp}));
  endtask : rd
  task automatic t_reset;
    rd(A_TRIM, 8'h00);
    rd(A_CTRL, 8'h00);
    rd(7'h01, 8'h00);
    rd(7'h7f, 8'h00);
    $display("reset test done");
  endtask : t_reset
  task automatic t_status;
    for (int k = 0; k < 5; k++)
    begin
      @(negedge clk);
      pins = {13{k[1:0]}};
      pins.driver_supply_level = 2'(k % 3);
      pins.sense_threshold_code = 3'(k);
      repeat (6) @(negedge clk);
      wr(A_OC, 8'h00);
      rd(A_OC, {2'b00, pins.overcurrent});
      rd(A_NOC, {2'b00, pins.reverse_current});
      rd(A_STAT, {5'h00, pins.ss_done, pins.max_current,
        pins.output_in_window});
      rd(A_CFG1, {2'b00, pins.current_pin_overrange,
        pins.driver_supply_level, pins.sense_threshold_code});
      rd(A_CFG2, {3'h0, pins.burst, pins.discontinuous_conduction,
        pins.outputs_high_impedance, pins.spread_switching_active,
        pins.buck_mode});
    end
    $display("status test done");
  endtask : t_status
  task automatic t_trim;
    @(negedge clk);
    pins = '0;
    pins.buck_mode = 1'b1;
    repeat (6) @(negedge clk);
    wr(A_TRIM, 8'hff);
    rd(A_TRIM, 8'h7f);
    chk({trim_sink, trim_code}, 8'hff);
    wr(A_TRIM, 8'h35);
    chk({trim_sink, trim_code}, 8'h35);
    ce = 1'b0;
    pins.buck_mode = 1'b0;
    repeat (10) @(negedge clk);
    chk({trim_active, trim_code}, 8'hb5);
    ce = 1'b1;
    repeat (10) @(negedge clk);
    chk({trim_active, trim_code}, 8'h00);
    rd(A_TRIM, 8'h35);
    $display("trim test done");
  endtask : t_trim
  task automatic t_wp;
    wr(A_CTRL, 8'h01);
    rd(A_CTRL, 8'h01);
    wr(A_TRIM, 8'h11);
    rd(A_TRIM, 8'h35);
    wr(A_CTRL, 8'h02);
    rd(A_CTRL, 8'h00);
    rd(A_TRIM, 8'h00);
    wr(A_TRIM, 8'h11);
    rd(A_TRIM, 8'h11);
    $display("protect test done");
  endtask : t_wp
  task automatic t_cml;
    wr(A_TRIM, 8'h22, 1'b1);
    rd(A_CTRL, 8'h04);
    rd(A_TRIM, 8'h11);
    wr(A_CTRL, 8'h00);
    rd(A_CTRL, 8'h04);
    wr(A_CTRL, 8'h04);
    rd(A_CTRL, 8'h00);
    $display("comm fault test done");
  endtask : t_cml
  initial
  begin
    #2000000;
    err_count++;
    summarize();
  end
  initial
  begin
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    repeat (8) @(negedge clk);
    t_reset();
    t_status();
    t_trim();
    t_wp();
    t_cml();
    summarize();
  end
endmodule : converter_status_control_regs_tb
`default_nettype wire
